// [hdl/metering_mode_and_irq_control.sv]
// Mode register upper half and interrupt status/enable bank, Avalon-MM slave.
// Assumes event inputs and reset_done_i are one-cycle pulses on sys_clk_i.
//
// Summary of operation
// - Swap bit routes channel 2 to converter 1.
// - Source field picks power, channel 1 or 2.
// - Bit 15 accumulates only positive power.
// - Mode fields load power-on defaults.
// - Each event except event_i[6] sets its sticky status flag.
// - Enabled set flag other than reset-done drives interrupt low.
// - Enable 0x0A, status 0x0B, clearing view 0x0C.
// - Reset-done flag never raises the interrupt.
// - Flags in bits 0..14, bit 15 reserved.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module metering_mode_and_irq_control #(
  parameter int SAMPLE_W = 24
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave, word addressed by byte address
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic [1:0] response_o,
  // Interrupt events, one bit per flag; event_i[6] is ignored
  input wire logic [14:0] event_i,
  // Software reset completion pulse, same clock
  input wire logic reset_done_i,
  // Signed power sample used by the accumulation gate
  input wire logic [SAMPLE_W-1:0] power_i,
  input wire logic power_valid_i,
  input wire logic [SAMPLE_W-1:0] ch1_i,
  input wire logic [SAMPLE_W-1:0] ch2_i,
  // Converter input routing
  output logic conv1_takes_ch2_o,
  output logic conv2_takes_ch1_o,
  output logic ch2_input_short_o,
  // Power term gated for the energy accumulator
  output logic [SAMPLE_W-1:0] accum_power_o,
  output logic accum_valid_o,
  // Waveform register
  output logic [SAMPLE_W-1:0] waveform_o,
  output logic waveform_strobe_o,
  output metering_pkg::mode_ctrl_t mode_o,
  // Interrupt request, active low
  output logic irq_n_o
);
  logic [15:0] mode_reg; // Full mode word; all 16 bits stored, bits 9..15 decoded
  logic [15:0] irq_enable_mask; // Enable bits
  logic [15:0] irq_flag; // Sticky flags
  logic [15:0] next_flag; // Flags after this cycle's set and clear
  logic [15:0] clear_mask; // Bits cleared by a read of the clearing view
  logic [15:0] raw_events; // Event pulses aligned to flag positions
  logic [31:0] next_readdata; // Decoded read word
  logic [1:0] next_response; // Decoded read/write response
  logic access_done; // Access is answered this cycle
  logic [SAMPLE_W-1:0] wave_sample;
  logic wave_strobe;
  metering_pkg::mode_ctrl_t ctrl; // Decoded mode fields

  // Address decode used by both read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx);
  endfunction

  // Byte-enable merge for a 16-bit register in the low lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Field decode of the mode word
  always_comb
  begin
    ctrl.ch2_input_short = mode_reg[metering_pkg::MODE_CH2_SHORT];
    ctrl.swap = mode_reg[metering_pkg::MODE_SWAP];
    ctrl.waveform_rate_select = mode_reg[metering_pkg::MODE_RATE_LO +: 2];
    ctrl.waveform_source_select = mode_reg[metering_pkg::MODE_SRC_LO +: 2];
    ctrl.positive_only_accumulate = mode_reg[metering_pkg::MODE_POS_ONLY];
  end

  // Waitrequest holds one cycle so every access answers on the second edge
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      waitrequest_o <= 1'b1;
    else if ((read_i || write_i) && waitrequest_o)
      waitrequest_o <= 1'b0;
    else
      waitrequest_o <= 1'b1;
  end

  assign access_done = (read_i || write_i) && !waitrequest_o;

  // Mode register write
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      mode_reg <= metering_pkg::MODE_RESET;
    else if (access_done && write_i && hit(address_i, metering_pkg::IDX_MODE))
      mode_reg <= merge16(mode_reg, writedata_i, byteenable_i);
  end

  // Enable register write; reserved bit 15 never stores
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_enable_mask <= 16'h0000;
    else if (access_done && write_i && hit(address_i, metering_pkg::IDX_IRQ_ENABLE))
      irq_enable_mask <= merge16(irq_enable_mask, writedata_i, byteenable_i)
                         & metering_pkg::FLAG_VALID;
  end

  // Event vector; reset completion lands on its own flag position
  always_comb
  begin
    raw_events = {1'b0, event_i} & metering_pkg::FLAG_VALID;
    raw_events[metering_pkg::FLAG_RESET_DONE] = reset_done_i;
  end

  // Reading the clearing view clears exactly the flags returned.
  // The read word was latched one edge before the accept edge, so a flag
  // that rose in between is not in it; clearing from the live flags would
  // drop that event unseen. The latched word is the mask instead.
  always_comb
  begin
    clear_mask = 16'h0000;
    if (access_done && read_i && hit(address_i, metering_pkg::IDX_IRQ_CLEAR))
      clear_mask = readdata_o[15:0];
    // A new event in the clearing cycle survives
    next_flag = (irq_flag & ~clear_mask) | raw_events;
  end

  // Sticky flags; the reset-done flag comes up on a reset_done_i pulse
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_flag <= 16'h0000;
    else
      irq_flag <= next_flag;
  end

  // Flag view held through hardware reset, cleared on the first edge after release.
  // Limitation: this view is not sticky; a host that must see it
  // has to read the status word right after reset ends.
  logic boot_pending;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      boot_pending <= 1'b1;
    else
      boot_pending <= 1'b0;
  end

  // Interrupt output; reset-done bit masked out of the request
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_n_o <= 1'b1;
    else
      irq_n_o <= ~|(next_flag & irq_enable_mask & metering_pkg::FLAG_IRQ_CAPABLE);
  end

  // Read data decode; unmapped addresses answer zero with a slave error
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    next_response = 2'h0;
    if (hit(address_i, metering_pkg::IDX_MODE))
      next_readdata = {16'h0000, mode_reg};
    else if (hit(address_i, metering_pkg::IDX_IRQ_ENABLE))
      next_readdata = {16'h0000, irq_enable_mask};
    else if (hit(address_i, metering_pkg::IDX_IRQ_FLAG) ||
             hit(address_i, metering_pkg::IDX_IRQ_CLEAR))
      next_readdata = {16'h0000, irq_flag | {15'h0000, boot_pending} << 6};
    else
      next_response = 2'h2;
  end

  // Registered read answer, valid on the edge waitrequest is low
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      readdata_o <= 32'h0000_0000;
      response_o <= 2'h0;
    end
    else if ((read_i || write_i) && waitrequest_o)
    begin
      readdata_o <= read_i ? next_readdata : 32'h0000_0000;
      response_o <= next_response;
    end
  end

  // Converter routing and input short
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      conv1_takes_ch2_o <= 1'b0;
      conv2_takes_ch1_o <= 1'b0;
      ch2_input_short_o <= 1'b0;
      mode_o <= '0;
    end
    else
    begin
      conv1_takes_ch2_o <= ctrl.swap;
      conv2_takes_ch1_o <= ctrl.swap;
      ch2_input_short_o <= ctrl.ch2_input_short;
      mode_o <= ctrl;
    end
  end

  // Accumulation gate; negative power zeroed in positive-only mode
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      accum_power_o <= '0;
      accum_valid_o <= 1'b0;
    end
    else
    begin
      accum_valid_o <= power_valid_i;
      if (ctrl.positive_only_accumulate && power_i[SAMPLE_W-1])
        accum_power_o <= '0;
      else
        accum_power_o <= power_i;
    end
  end

  waveform_sampler #(
    .SAMPLE_W(SAMPLE_W)
  ) u_sampler (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .rate_i(ctrl.waveform_rate_select),
    .source_i(ctrl.waveform_source_select),
    .power_i(power_i),
    .ch1_i(ch1_i),
    .ch2_i(ch2_i),
    .sample_o(wave_sample),
    .strobe_o(wave_strobe)
  );

  // Waveform register output stage
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      waveform_o <= '0;
      waveform_strobe_o <= 1'b0;
    end
    else
    begin
      waveform_o <= wave_sample;
      waveform_strobe_o <= wave_strobe;
    end
  end
endmodule // metering_mode_and_irq_control

// [include/metering_pkg.sv]
// Package for the metering mode and interrupt control register bank.
// Assumes a 16-bit register view carried in the low bits of a 32-bit Avalon-MM word.
package metering_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE = 6'h09;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0a;
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h0b;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h0c;
  // Mode field positions
  localparam int MODE_CH2_SHORT = 9;
  localparam int MODE_SWAP = 10;
  localparam int MODE_RATE_LO = 11;
  localparam int MODE_SRC_LO = 13;
  localparam int MODE_POS_ONLY = 15;
  // Power-on default of the mode register; fields 9..15 start at zero
  localparam logic [15:0] MODE_RESET = 16'h000c;
  // Interrupt flag layout
  localparam int FLAG_RESET_DONE = 6;
  localparam logic [15:0] FLAG_VALID = 16'h7fff;
  localparam logic [15:0] FLAG_IRQ_CAPABLE = 16'h7fbf;
  // Waveform source codes
  localparam logic [1:0] SRC_POWER = 2'h0;
  localparam logic [1:0] SRC_CH1 = 2'h2;
  localparam logic [1:0] SRC_CH2 = 2'h3;
  // Waveform rate divider base: code n divides by 128 << n
  localparam int RATE_BASE_LOG2 = 7;
  // Decoded mode controls, carried together
  typedef struct packed {
    logic ch2_input_short;
    logic swap;
    logic [1:0] waveform_rate_select;
    logic [1:0] waveform_source_select;
    logic positive_only_accumulate;
  } mode_ctrl_t;
endpackage

// [hdl/waveform_sampler.sv]
// Waveform sample selector and rate timer.
// Assumes samples arrive on sys_clk_i and the rate code is stable between writes.
`timescale 1ns/1ps
module waveform_sampler #(
  parameter int SAMPLE_W = 24
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] rate_i,
  input wire logic [1:0] source_i,
  input wire logic [SAMPLE_W-1:0] power_i,
  input wire logic [SAMPLE_W-1:0] ch1_i,
  input wire logic [SAMPLE_W-1:0] ch2_i,
  output logic [SAMPLE_W-1:0] sample_o,
  output logic strobe_o
);
  // Free-running divider; 10 bits cover the slowest rate of 1024
  logic [9:0] div_cnt;
  logic [9:0] div_last;

  // Terminal count from the rate code
  always_comb
  begin
    div_last = 10'((1 << (metering_pkg::RATE_BASE_LOG2 + int'(rate_i))) - 1);
  end

  // Divider; restarts when a faster code shortens the period under it
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_cnt <= 10'h000;
    else if (div_cnt >= div_last)
      div_cnt <= 10'h000;
    else
      div_cnt <= div_cnt + 10'h001;
  end

  // Latch the selected source at each rate tick; reserved code keeps the old sample
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sample_o <= '0;
      strobe_o <= 1'b0;
    end
    else
    begin
      strobe_o <= (div_cnt >= div_last);
      if (div_cnt >= div_last)
      begin
        unique case (source_i)
          metering_pkg::SRC_POWER: sample_o <= power_i;
          metering_pkg::SRC_CH1: sample_o <= ch1_i;
          metering_pkg::SRC_CH2: sample_o <= ch2_i;
          default: sample_o <= sample_o;
        endcase
      end
    end
  end
endmodule // waveform_sampler

// [tb/mode_irq_checker.sv]
// Concurrent checks on the mode and interrupt bank ports.
// Assumes it is bound to the top module.
`timescale 1ns/1ps
module mode_irq_checker #(
  parameter int SAMPLE_W = 24
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [14:0] event_i,
  input wire logic reset_done_i,
  input wire logic [SAMPLE_W-1:0] power_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic [1:0] response_o,
  input wire logic conv1_takes_ch2_o,
  input wire logic conv2_takes_ch1_o,
  input wire logic ch2_input_short_o,
  input wire logic [SAMPLE_W-1:0] accum_power_o,
  input wire logic waveform_strobe_o,
  input wire metering_pkg::mode_ctrl_t mode_o,
  input wire logic irq_n_o
);
  // One domain; reset quiets every check
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Request hits one of the four mapped words
  logic mapped;
  assign mapped = address_i[7:2] inside {[6'h09:6'h0c]};
  chk_swap_pair: assert property (conv1_takes_ch2_o == mode_o.swap && conv2_takes_ch1_o == mode_o.swap)
    else $error("routing differs from swap");
  chk_short_follow: assert property (ch2_input_short_o == mode_o.ch2_input_short)
    else $error("short differs from mode");
  chk_pos_gate: assert property ($past(mode_o.positive_only_accumulate) && mode_o.positive_only_accumulate && $past(power_i[SAMPLE_W-1]) |-> accum_power_o == '0)
    else $error("negative power passed");
  chk_strobe_pulse: assert property (waveform_strobe_o |=> !waveform_strobe_o)
    else $error("strobe longer than a cycle");
  chk_wait_answer: assert property ($rose(read_i || write_i) |-> ##1 !waitrequest_o)
    else $error("late bus answer");
  chk_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("accept held too long");
  chk_map_error: assert property (!waitrequest_o && read_i && !mapped |-> response_o == 2'h2 && readdata_o == '0)
    else $error("unmapped read not refused");
  chk_map_ok: assert property (!waitrequest_o && (read_i || write_i) && mapped |-> response_o == 2'h0 && readdata_o[31:16] == 16'h0000)
    else $error("mapped access refused");
  chk_flag_top: assert property (!waitrequest_o && read_i && address_i[7:2] inside {[6'h0a:6'h0c]} |-> !readdata_o[15])
    else $error("reserved flag bit set");
  chk_irq_cause: assert property ($fell(irq_n_o) |-> $past(event_i) != '0 || $past(event_i, 2) != '0 || $past(write_i) || $past(write_i, 2))
    else $error("irq without cause");
  chk_reset_quiet: assert property ($past(reset_done_i) && $past(event_i) == '0 && $past(irq_n_o) && !$past(write_i) |-> irq_n_o)
    else $error("reset flag raised irq");
endmodule // mode_irq_checker

// [tb/host_model.sv]
// Host model: Avalon-MM master and interrupt service routine.
// Assumes the bank lowers waitrequest to accept each request.
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk_i,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i,
  input wire logic [1:0] response_i,
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o
);
  // Idle bus from time zero; only the low two lanes carry data
  initial
  begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h00000000;
    byteenable_o = 4'h3;
  end
  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [15:0] wd,
                      output logic [31:0] rd, output logic [1:0] rsp);
    @(posedge sys_clk_i);
    address_o <= adr;
    writedata_o <= {16'h0000, wd};
    write_o <= wr;
    read_o <= !wr;
    do
      @(posedge sys_clk_i);
    while (waitrequest_i !== 1'b0);
    rd = readdata_i;
    rsp = response_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
  // Service reads the plain status first, then the clearing view
  task automatic service(output logic [15:0] seen, output logic [15:0] cleared);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'b0, 8'h2c, 16'h0000, q, r);
    seen = q[15:0];
    xfer(1'b0, 8'h30, 16'h0000, q, r);
    cleared = q[15:0];
  endtask
endmodule // host_model

// [tb/testbench.sv]
// Self-checking bench for the mode and interrupt bank.
// Assumes a 200 MHz clock and the host model on the register bus.
`timescale 1ns/1ps
`define CHK(nm, ex, ob) begin tests_run++; if ((ob) !== (ex)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, ob); end end
module testbench;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] address_i;
  logic read_i, write_i, waitrequest_o, reset_done_i = 1'b0, power_valid_i = 1'b0;
  logic [31:0] writedata_i, readdata_o, q;
  logic [3:0] byteenable_i;
  logic [1:0] response_o, r;
  logic [14:0] event_i = 15'h0000;
  logic [23:0] power_i = 24'h0, ch1_i = 24'h0, ch2_i = 24'h0, accum_power_o, waveform_o;
  logic conv1_takes_ch2_o, conv2_takes_ch1_o, ch2_input_short_o, accum_valid_o;
  logic waveform_strobe_o, irq_n_o;
  logic [15:0] s, c, d;
  metering_pkg::mode_ctrl_t mode_o;
  // Source per rate step; reserved code first, while the sample is still zero
  logic [1:0] src_tab [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  int errors = 0;
  int tests_run = 0;
  int cnt;
  always #2.5 sys_clk_i = ~sys_clk_i;
  metering_mode_and_irq_control dut (.*);
  host_model host (.sys_clk_i(sys_clk_i), .readdata_i(readdata_o), .waitrequest_i(waitrequest_o),
    .response_i(response_o), .address_o(address_i), .read_o(read_i), .write_o(write_i),
    .writedata_o(writedata_i), .byteenable_o(byteenable_i));
  // Bus helpers
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    host.xfer(1'b1, a, v, q, r);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 16'h0000, q, r);
  endtask
  // Expected waveform sample for a source code
  function automatic logic [23:0] wave_exp(input logic [1:0] src);
    case (src)
      2'h0: return power_i;
      2'h2: return ch1_i;
      2'h3: return ch2_i;
      default: return 24'h000000;
    endcase
  endfunction
  task results;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the longest expected run
  initial
  begin
    #250000;
    errors++;
    results();
  end
  initial
  begin
    q = $urandom(98);
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd(8'h24);
    `CHK("mode reset", 32'h0000000c, q)
    `CHK("mode fields", 7'h00, mode_o)
    rd(8'h00);
    `CHK("unmapped rsp", 2'h2, r)
    $display("test reset done");
    // Each flag alone; bit 6 of the event bus must be ignored
    for (int n = 0; n < 15; n++)
    begin
      if (n == 6)
        continue;
      wr(8'h28, 16'h0001 << n);
      @(posedge sys_clk_i);
      event_i <= (15'h0001 << n) | 15'h0040;
      @(posedge sys_clk_i);
      event_i <= 15'h0000;
      @(negedge sys_clk_i);
      `CHK("irq low", 1'b0, irq_n_o)
      host.service(s, c);
      `CHK("status", 16'h0001 << n, s)
      `CHK("cleared", 16'h0001 << n, c)
      rd(8'h2c);
      `CHK("after clear", 32'h0, q)
      `CHK("irq high", 1'b1, irq_n_o)
    end
    $display("test flags done");
    // Masked flags stay silent; reset-done never interrupts
    wr(8'h28, 16'h0000);
    event_i <= 15'h7fbf;
    reset_done_i <= 1'b1;
    @(posedge sys_clk_i);
    event_i <= 15'h0000;
    reset_done_i <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    `CHK("masked", 1'b1, irq_n_o)
    wr(8'h28, 16'h0040);
    reset_done_i <= 1'b1;
    @(posedge sys_clk_i);
    reset_done_i <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    `CHK("reset quiet", 1'b1, irq_n_o)
    wr(8'h28, 16'h7fff);
    repeat (2) @(negedge sys_clk_i);
    `CHK("late enable", 1'b0, irq_n_o)
    host.service(s, c);
    `CHK("all flags", 16'h7fbf, c & 16'hffbf)
    $display("test mask done");
    // Random mode fields, one rate code per pass
    for (int i = 0; i < 4; i++)
    begin
      d = {1'($urandom), src_tab[i], 2'(i), 2'($urandom), 9'h00c};
      wr(8'h24, d);
      power_i <= 24'($urandom);
      power_valid_i <= 1'b1;
      ch1_i <= 24'($urandom);
      ch2_i <= 24'($urandom);
      rd(8'h24);
      `CHK("mode read", {16'h0000, d}, q)
      `CHK("pos only", d[15], mode_o.positive_only_accumulate)
      `CHK("swap", {2{d[10]}}, {conv1_takes_ch2_o, conv2_takes_ch1_o})
      `CHK("short", d[9], ch2_input_short_o)
      `CHK("accum", (d[15] && power_i[23]) ? 24'h0 : power_i, accum_power_o)
      `CHK("accum valid", 1'b1, accum_valid_o)
      // First gap may be partial, so time the second one
      repeat (2)
      begin
        cnt = 0;
        do
        begin
          @(negedge sys_clk_i);
          cnt++;
        end
        while (waveform_strobe_o !== 1'b1 && cnt < 2000);
      end
      `CHK("rate", 128 << i, cnt)
      `CHK("wave", wave_exp(src_tab[i]), waveform_o)
    end
    $display("test mode done");
    results();
  end
endmodule // testbench
bind metering_mode_and_irq_control mode_irq_checker #(.SAMPLE_W(SAMPLE_W)) chk (.*);
